// ==== core/agpbr_cfg_header.sv ====
`timescale 1ns/1ps
`include "agpbr_map.svh"
// Contract
// - revision byte is read-only; writes leave it unchanged.
// - sub-class byte returns fixed 04h (PCI-to-PCI bridge category), read-only.
// - base class byte returns fixed 06h, read-only.
// - primary latency bits 7:3 plain storage; bits 2:0 reserved.
// - header type reads 01h always; writes ignored.
// - upstream bus number hardwired to zero.
// - downstream bus number read/write, resets 00h, routes config cycles.
// - highest bus below read/write, resets 00h.
// - burst timer loads when first frame starts after grant.
// - count is bits 7:3 with low bits zero, in link clocks.
// - after expiry with grant withdrawn, finish phase then release bus.
// - while grant stays asserted, keep bus ownership.
// - deassert frame before the last data transfer.
// - timer value zero means unlimited burst.
// - io base holds A15:12, reset F0h, low bits taken as zero.
// - io limit holds A15:12, reset zero, low bits taken as fff.
// - forward io access when 16-bit address within base..limit inclusive.
// - io forwarding only while io space enable bit is set.
module agpbr_cfg_header #(
  // arbitrary neutral revision value
  parameter logic [7:0] REVISION_ID = 8'h11
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // configuration access
  input wire logic cfg_rd_i,
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_rdata_o,
  // host io decode
  input wire logic [15:0] io_addr_i,
  input wire logic io_req_i,
  output logic io_fwd_o,
  // config cycle routing
  input wire logic [7:0] cfg_bus_i,
  input wire logic cfg_cyc_i,
  output logic cfg_fwd_o,
  output logic cfg_type0_o,
  // link master side
  input wire logic gnt_b_i,
  input wire logic burst_req_i,
  input wire logic burst_last_i,
  output logic frame_b_o,
  output logic frame_oe_o,
  output logic bus_own_o
);
  typedef struct packed {
    logic [7:0] rdata;
    logic [4:0] plat;
    logic [7:0] sbus;
    logic [7:0] subus;
    logic [4:0] slat;
    logic [3:0] iobase;
    logic [3:0] iolim;
    logic ioen;
    logic gnt_m;
    logic gnt_s;
    logic own;
    logic frame;
    logic first;
    agpbr_pkg::agpbr_bus_e bst;
  } agpbr_hdr_s;

  agpbr_hdr_s st;
  agpbr_hdr_s next_st;
  agpbr_tenure_if tif ();

  agpbr_tenure_timer u_timer (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .tif(tif)
  );

  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  function automatic agpbr_pkg::agpbr_byte_t read_mux(input logic [7:0] a, input agpbr_hdr_s s);
    case (a)
      `AGPBR_OFF_REV: read_mux = REVISION_ID;
      `AGPBR_OFF_SUBC: read_mux = `AGPBR_SUBC_VAL;
      `AGPBR_OFF_BASE_CLASS_FIELD: read_mux = `AGPBR_BASE_CLASS_FIELD_VAL;
      `AGPBR_OFF_PLAT: read_mux = {s.plat, 3'h0};
      `AGPBR_OFF_HDR: read_mux = `AGPBR_HDR_VAL;
      `AGPBR_OFF_PBUS: read_mux = `AGPBR_PBUS_VAL;
      `AGPBR_OFF_SBUS: read_mux = s.sbus;
      `AGPBR_OFF_SUBUS: read_mux = s.subus;
      `AGPBR_OFF_SLAT: read_mux = {s.slat, 3'h0};
      `AGPBR_OFF_IOBASE: read_mux = {s.iobase, 4'h0};
      `AGPBR_OFF_IOLIM: read_mux = {s.iolim, 4'h0};
      `AGPBR_OFF_CMD: read_mux = {7'h00, s.ioen};
      default: read_mux = 8'h00;
    endcase
  endfunction

  logic [15:0] io_lo;
  logic [15:0] io_hi;
  logic gnt;

  assign io_lo = {st.iobase, `AGPBR_IO_LOW_BASE};
  assign io_hi = {st.iolim, `AGPBR_IO_LOW_LIM};
  // grant is a pin: only the second synchroniser stage is read
  assign gnt = !st.gnt_s;

  always_comb
  begin
    next_st = st;
    next_st.gnt_m = gnt_b_i;
    next_st.gnt_s = st.gnt_m;
    if (cfg_rd_i)
      next_st.rdata = read_mux(cfg_addr_i, st);
    if (cfg_wr_i)
    begin
      case (cfg_addr_i)
        `AGPBR_OFF_PLAT: next_st.plat = cfg_wdata_i[`AGPBR_LAT_MSB:`AGPBR_LAT_LSB];
        `AGPBR_OFF_SBUS: next_st.sbus = cfg_wdata_i;
        `AGPBR_OFF_SUBUS: next_st.subus = cfg_wdata_i;
        `AGPBR_OFF_SLAT: next_st.slat = cfg_wdata_i[`AGPBR_LAT_MSB:`AGPBR_LAT_LSB];
        `AGPBR_OFF_IOBASE: next_st.iobase = cfg_wdata_i[`AGPBR_IO_MSB:`AGPBR_IO_LSB];
        `AGPBR_OFF_IOLIM: next_st.iolim = cfg_wdata_i[`AGPBR_IO_MSB:`AGPBR_IO_LSB];
        `AGPBR_OFF_CMD: next_st.ioen = cfg_wdata_i[`AGPBR_CMD_IOEN];
        default: next_st.rdata = next_st.rdata;
      endcase
    end
    // ownership follows grant; a fresh grant re-arms the first frame
    if (gnt && !st.own)
    begin
      next_st.own = 1'b1;
      next_st.first = 1'b1;
    end
    case (st.bst)
      agpbr_pkg::AGPBR_IDLE:
      begin
        if (!gnt && st.own)
          next_st.own = 1'b0;
        else if (st.own && burst_req_i)
        begin
          next_st.frame = 1'b1;
          next_st.first = 1'b0;
          // single phase drops frame at once
          next_st.bst = burst_last_i ? agpbr_pkg::AGPBR_LAST : agpbr_pkg::AGPBR_BURST;
        end
      end
      agpbr_pkg::AGPBR_BURST:
      begin
        // expiry plus lost grant ends the burst
        if (burst_last_i || (tif.expired && !gnt))
        begin
          // frame negated before the final transfer
          next_st.frame = 1'b0;
          next_st.bst = agpbr_pkg::AGPBR_LAST;
        end
      end
      agpbr_pkg::AGPBR_LAST:
      begin
        next_st.frame = 1'b0;
        next_st.bst = agpbr_pkg::AGPBR_IDLE;
        // release after final phase if grant gone
        if (!gnt)
          next_st.own = 1'b0;
      end
      default:
      begin
        next_st.frame = 1'b0;
        next_st.bst = agpbr_pkg::AGPBR_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      st <= '0;
      st.plat <= `AGPBR_RST_LAT;
      st.sbus <= `AGPBR_RST_BUS;
      st.subus <= `AGPBR_RST_BUS;
      st.slat <= `AGPBR_RST_LAT;
      st.iobase <= `AGPBR_RST_IOBASE;
      st.iolim <= `AGPBR_RST_IOLIM;
      st.gnt_m <= 1'b1;
      st.gnt_s <= 1'b1;
      st.bst <= agpbr_pkg::AGPBR_IDLE;
    end
    else
      st <= next_st;
  end

  // load at the first frame after grant
  assign tif.start = (st.bst == agpbr_pkg::AGPBR_IDLE) && st.own && gnt && burst_req_i && st.first;
  assign tif.count_hi = st.slat;
  assign tif.gnt = gnt;

  assign cfg_rdata_o = st.rdata;
  // inclusive 16-bit window; gated by enable; base 00h is firmware's hazard
  assign io_fwd_o = io_req_i && st.ioen && in_range(io_addr_i, io_lo, io_hi);
  assign cfg_fwd_o = cfg_cyc_i && in_range({8'h00, cfg_bus_i}, {8'h00, st.sbus}, {8'h00, st.subus});
  assign cfg_type0_o = cfg_cyc_i && (cfg_bus_i == st.sbus);
  assign frame_b_o = !st.frame;
  assign frame_oe_o = st.own;
  assign bus_own_o = st.own;
endmodule

// ==== core/agpbr_map.svh ====
`ifndef AGPBR_MAP_SVH
`define AGPBR_MAP_SVH
// configuration offsets (byte index inside the function's header)
`define AGPBR_OFF_REV 8'h08
`define AGPBR_OFF_SUBC 8'h0a
`define AGPBR_OFF_BASE_CLASS_FIELD 8'h0b
`define AGPBR_OFF_PLAT 8'h0d
`define AGPBR_OFF_HDR 8'h0e
`define AGPBR_OFF_PBUS 8'h18
`define AGPBR_OFF_SBUS 8'h19
`define AGPBR_OFF_SUBUS 8'h1a
`define AGPBR_OFF_SLAT 8'h1b
`define AGPBR_OFF_IOBASE 8'h1c
`define AGPBR_OFF_IOLIM 8'h1d
`define AGPBR_OFF_CMD 8'h04
// fixed and reset values
`define AGPBR_SUBC_VAL 8'h04
`define AGPBR_BASE_CLASS_FIELD_VAL 8'h06
`define AGPBR_HDR_VAL 8'h01
`define AGPBR_PBUS_VAL 8'h00
`define AGPBR_RST_BUS 8'h00
`define AGPBR_RST_LAT 5'h00
`define AGPBR_RST_IOBASE 4'hf
`define AGPBR_RST_IOLIM 4'h0
// field positions
`define AGPBR_LAT_MSB 7
`define AGPBR_LAT_LSB 3
`define AGPBR_IO_MSB 7
`define AGPBR_IO_LSB 4
`define AGPBR_CMD_IOEN 0
// decode fill for low twelve address bits
`define AGPBR_IO_LOW_BASE 12'h000
`define AGPBR_IO_LOW_LIM 12'hfff
`endif

// ==== core/agpbr_pkg.sv ====
package agpbr_pkg;
  typedef enum logic [1:0] {
    AGPBR_IDLE,
    AGPBR_BURST,
    AGPBR_LAST
  } agpbr_bus_e;
  typedef logic [7:0] agpbr_byte_t;
endpackage

// ==== core/agpbr_tenure_if.sv ====
`timescale 1ns/1ps
interface agpbr_tenure_if;
  logic start;
  logic [4:0] count_hi;
  logic gnt;
  logic expired;
  modport owner (output start, output count_hi, output gnt, input expired);
  modport timer (input start, input count_hi, input gnt, output expired);
endinterface

// ==== core/agpbr_tenure_timer.sv ====
`timescale 1ns/1ps
module agpbr_tenure_timer (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // link to owner
  agpbr_tenure_if.timer tif
);
  typedef struct packed {
    logic [7:0] cnt;
    logic running;
    logic expired;
  } agpbr_timer_s;
  agpbr_timer_s st;
  agpbr_timer_s next_st;

  always_comb
  begin
    next_st = st;
    if (tif.start)
    begin
      next_st.cnt = {tif.count_hi, 3'h0};
      next_st.running = (tif.count_hi != 5'h00);
      next_st.expired = 1'b0;
    end
    else if (st.running)
    begin
      if (st.cnt <= 8'h01)
      begin
        next_st.running = 1'b0;
        next_st.expired = 1'b1;
      end
      next_st.cnt = st.cnt - 8'h01;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign tif.expired = st.expired;
endmodule

// ==== tb/agpbr_agp_peer.sv ====
`timescale 1ns/1ps
module agpbr_agp_peer #(
  parameter int DLY = 2
) (
  // clock
  input wire logic mclk_i,
  // peer request and grant pin
  input wire logic peer_req_i,
  output logic gnt_b_o
);
  int cnt;
  initial
  begin
    cnt = 0;
    gnt_b_o = 1'b1;
  end
  // grant held while peer idle; slow answer via DLY
  always @(negedge mclk_i)
  begin
    cnt <= peer_req_i ? cnt + 1 : 0;
    gnt_b_o <= peer_req_i && cnt >= DLY;
  end
endmodule

// ==== tb/agpbr_cfg_header_assertions.sv ====
`timescale 1ns/1ps
module agpbr_cfg_header_assertions #(
  parameter logic [7:0] REVISION_ID = 8'h11
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // watched ports
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [7:0] cfg_rdata_o,
  input wire logic io_req_i,
  input wire logic io_fwd_o,
  input wire logic frame_b_o,
  input wire logic frame_oe_o,
  input wire logic bus_own_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  chk_rev_fixed: assert property (
    cfg_rd_i && cfg_addr_i == 8'h08 |=> cfg_rdata_o == REVISION_ID) else $error("revision byte wrong");
  chk_subc_fixed: assert property (
    cfg_rd_i && cfg_addr_i == 8'h0a |=> cfg_rdata_o == 8'h04) else $error("sub-class byte wrong");
  chk_base_class_field_fixed: assert property (
    cfg_rd_i && cfg_addr_i == 8'h0b |=> cfg_rdata_o == 8'h06) else $error("base class byte wrong");
  chk_lat_low_zero: assert property (
    cfg_rd_i && cfg_addr_i inside {8'h0d, 8'h1b} |=> cfg_rdata_o[2:0] == 3'h0) else $error("latency low bits set");
  chk_hdr_fixed: assert property (
    cfg_rd_i && cfg_addr_i == 8'h0e |=> cfg_rdata_o == 8'h01) else $error("header type wrong");
  chk_pbus_zero: assert property (
    cfg_rd_i && cfg_addr_i == 8'h18 |=> cfg_rdata_o == 8'h00) else $error("primary bus not zero");
  chk_io_low_zero: assert property (
    cfg_rd_i && cfg_addr_i inside {8'h1c, 8'h1d} |=> cfg_rdata_o[3:0] == 4'h0) else $error("io low bits set");
  chk_io_gated: assert property (
    !io_req_i |-> !io_fwd_o) else $error("io forwarded without request");
  chk_frame_owned: assert property (
    !frame_b_o |-> frame_oe_o && bus_own_o) else $error("frame driven without ownership");
endmodule

bind agpbr_cfg_header agpbr_cfg_header_assertions #(.REVISION_ID(REVISION_ID)) i_agpbr_cfg_header_assertions (.*);

// ==== tb/test_agp_bridge_config_header.sv ====
`timescale 1ns/1ps
module test_agp_bridge_config_header;
  logic mclk_i, rst_b_i, cfg_rd_i, cfg_wr_i, io_req_i, io_fwd_o, cfg_cyc_i, cfg_fwd_o, cfg_type0_o;
  logic gnt_b_i, burst_req_i, burst_last_i, frame_b_o, frame_oe_o, bus_own_o, peer_req;
  logic [7:0] cfg_addr_i, cfg_wdata_i, cfg_rdata_o, cfg_bus_i;
  logic [15:0] io_addr_i;
  int n_fail = 0;
  int comparisons = 0;
  logic [7:0] ad [12] = '{8'h08, 8'h0a, 8'h0b, 8'h0d, 8'h0e, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h30};
  logic [7:0] rv [12] = '{8'h11, 8'h04, 8'h06, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'hf0, 8'h00, 8'h00};
  logic [7:0] fv [12] = '{8'h11, 8'h04, 8'h06, 8'hf8, 8'h01, 8'h00, 8'hff, 8'hff, 8'hf8, 8'hf0, 8'hf0, 8'h00};
  logic [15:0] ia [4] = '{16'h1fff, 16'h2000, 16'h3fff, 16'h4000};
  logic [7:0] bn [4] = '{8'h04, 8'h05, 8'h07, 8'h08};
  logic [3:0] ex = 4'b0110;
  agpbr_cfg_header i_agpbr_cfg_header (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .cfg_rd_i(cfg_rd_i),
    .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
    .io_addr_i(io_addr_i), .io_req_i(io_req_i), .io_fwd_o(io_fwd_o), .cfg_bus_i(cfg_bus_i),
    .cfg_cyc_i(cfg_cyc_i), .cfg_fwd_o(cfg_fwd_o), .cfg_type0_o(cfg_type0_o), .gnt_b_i(gnt_b_i),
    .burst_req_i(burst_req_i), .burst_last_i(burst_last_i), .frame_b_o(frame_b_o),
    .frame_oe_o(frame_oe_o), .bus_own_o(bus_own_o));
  agpbr_agp_peer i_agpbr_agp_peer (.mclk_i(mclk_i), .peer_req_i(peer_req), .gnt_b_o(gnt_b_i));
  always #25 mclk_i = ~mclk_i;
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    cfg_addr_i = a;
    cfg_wdata_i = d;
    cfg_wr_i = 1'b1;
    @(negedge mclk_i);
    cfg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk_i);
    cfg_addr_i = a;
    cfg_rd_i = 1'b1;
    @(negedge mclk_i);
    cfg_rd_i = 1'b0;
    chk("rdata", cfg_rdata_o, e);
  endtask
  // bounded wait for ownership (sel=1) or frame (sel=0) to reach v
  task automatic wt(input bit sel, input logic v);
    for (int k = 0; k < 40 && (sel ? bus_own_o : frame_b_o) !== v; k++)
      @(negedge mclk_i);
    chk(sel ? "own" : "frame", sel ? bus_own_o : frame_b_o, v);
  endtask
  task automatic results();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #200000;
    n_fail++;
    results();
  end
  initial
  begin
    mclk_i = 1'b0;
    rst_b_i = 1'b0;
    cfg_rd_i = 1'b0;
    cfg_wr_i = 1'b0;
    cfg_addr_i = 8'h00;
    cfg_wdata_i = 8'h00;
    io_addr_i = 16'h0000;
    io_req_i = 1'b0;
    cfg_bus_i = 8'h00;
    cfg_cyc_i = 1'b0;
    burst_req_i = 1'b0;
    burst_last_i = 1'b0;
    peer_req = 1'b0;
    repeat (4) @(negedge mclk_i);
    rst_b_i = 1'b1;
    for (int i = 0; i < 12; i++)
      rd(ad[i], rv[i]);
    for (int i = 0; i < 12; i++)
      wr(ad[i], 8'hff);
    for (int i = 0; i < 12; i++)
      rd(ad[i], fv[i]);
    wr(8'h1c, 8'h20);
    wr(8'h1d, 8'h30);
    wr(8'h19, 8'h05);
    wr(8'h1a, 8'h07);
    for (int en = 0; en < 2; en++)
    begin
      wr(8'h04, en[7:0]);
      for (int i = 0; i < 4; i++)
      begin
        @(negedge mclk_i);
        io_addr_i = ia[i];
        io_req_i = 1'b1;
        cfg_bus_i = bn[i];
        cfg_cyc_i = 1'b1;
        #1;
        chk("io_fwd", io_fwd_o, ex[i] & en[0]);
        chk("cfg_fwd", cfg_fwd_o, ex[i]);
        chk("type0", cfg_type0_o, i == 1);
      end
    end
    wr(8'h1b, 8'h08);
    burst_req_i = 1'b1;
    wt(1'b0, 1'b0);
    repeat (30) @(negedge mclk_i);
    chk("own", bus_own_o, 1'b1);
    chk("frame_oe", frame_oe_o, 1'b1);
    peer_req = 1'b1;
    wt(1'b1, 1'b0);
    peer_req = 1'b0;
    wt(1'b0, 1'b0);
    peer_req = 1'b1;
    repeat (7) @(negedge mclk_i);
    chk("frame", frame_b_o, 1'b0);
    wt(1'b1, 1'b0);
    wr(8'h1b, 8'h00);
    peer_req = 1'b0;
    wt(1'b0, 1'b0);
    peer_req = 1'b1;
    repeat (20) @(negedge mclk_i);
    chk("own", bus_own_o, 1'b1);
    burst_last_i = 1'b1;
    @(negedge mclk_i);
    burst_last_i = 1'b0;
    burst_req_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    chk("frame", frame_b_o, 1'b1);
    chk("frame_oe", frame_oe_o, 1'b0);
    results();
  end
endmodule
